//--- rtl/mdu_defs.svh
// Shared constants of the multiply/divide unit.
`ifndef MDU_DEFS_SVH
`define MDU_DEFS_SVH

`define MDU_WORD 32
`define MDU_HALF 16
`define MDU_BOOTH_DIGITS 9
`define MDU_DIV_SKIP_8 6'h17
`define MDU_DIV_SKIP_16 6'h0F
`define MDU_DIV_SKIP_24 6'h07
`define MDU_DIV_SKIP_32 6'h00
`define MDU_DIV_REPEAT_8 6'h0B
`define MDU_DIV_REPEAT_16 6'h12
`define MDU_DIV_REPEAT_24 6'h19
`define MDU_DIV_REPEAT_32 6'h20
`define MDU_DIV_ITER_FULL 6'h20

`endif

//--- rtl/mdu_div_if.sv
// Signals between the unit's control and its divider.
`timescale 1ns/1ps
`default_nettype none

interface mdu_div_if;
    logic start;
    logic isSigned;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [31:0] quotient;
    logic [31:0] remainder;
    logic busy;
    logic done;

    modport divider (
        input start, isSigned, dividend, divisor,
        output quotient, remainder, busy, done
    );
    modport control (
        output start, isSigned, dividend, divisor,
        input quotient, remainder, busy, done
    );
endinterface : mdu_div_if

`default_nettype wire

//--- rtl/mdu_divider.sv
// Iterative restoring divider, one quotient bit per clock, with early-in skip.
`timescale 1ns/1ps
`default_nettype none
`include "mdu_defs.svh"

module mdu_divider
    import mdu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    mdu_div_if.divider div
);

    // ==========================================================
    // Start decode
    // ==========================================================
    wire logic [31:0] dividendMag;
    wire logic [31:0] divisorMag;
    wire logic fits8;
    wire logic fits16;
    wire logic fits24;
    wire logic [5:0] skipCount;
    wire logic [5:0] repeatCount;
    wire logic [5:0] iterCount;
    wire logic startStep;

    assign dividendMag = (div.isSigned && div.dividend[31]) ? -div.dividend : div.dividend;
    assign divisorMag = (div.isSigned && div.divisor[31]) ? -div.divisor : div.divisor;
    assign fits8 = div.isSigned ? (&div.dividend[31:7] | ~|div.dividend[31:7])
                                : ~|div.dividend[31:8];
    assign fits16 = div.isSigned ? (&div.dividend[31:15] | ~|div.dividend[31:15])
                                 : ~|div.dividend[31:16];
    assign fits24 = div.isSigned ? (&div.dividend[31:23] | ~|div.dividend[31:23])
                                 : ~|div.dividend[31:24];
    assign skipCount = fits8 ? `MDU_DIV_SKIP_8 : fits16 ? `MDU_DIV_SKIP_16 :
                       fits24 ? `MDU_DIV_SKIP_24 : `MDU_DIV_SKIP_32; // RULE_06
    assign repeatCount = fits8 ? `MDU_DIV_REPEAT_8 : fits16 ? `MDU_DIV_REPEAT_16 :
                         fits24 ? `MDU_DIV_REPEAT_24 : `MDU_DIV_REPEAT_32; // RULE_10
    assign iterCount = `MDU_DIV_ITER_FULL - skipCount;
    // The longer classes have no spare cycle, so their first bit is resolved at start.
    assign startStep = (iterCount == repeatCount);

    function automatic logic [64:0] divStep(input logic [32:0] rem, input logic [31:0] quo,
                                            input logic [31:0] dvs);
        logic [32:0] shifted;
        logic [32:0] trial;
        shifted = {rem[31:0], quo[31]};
        trial = shifted - {1'b0, dvs};
        divStep = trial[32] ? {shifted, quo[30:0], 1'b0} : {trial, quo[30:0], 1'b1};
    endfunction : divStep

    // ==========================================================
    // State
    // ==========================================================
    mdu_div_state_type state_reg;
    mdu_div_state_type state_next;
    logic [32:0] rem_reg;
    logic [31:0] quo_reg;
    logic [31:0] divisor_reg;
    logic [4:0] cnt_reg;
    logic [5:0] iterLeft_reg;
    logic negQuo_reg;
    logic negRem_reg;

    wire logic [64:0] startStepped;
    wire logic [64:0] runStepped;
    wire logic doStep;

    assign startStepped = divStep(33'h0_0000_0000, dividendMag << skipCount, divisorMag);
    assign runStepped = divStep(rem_reg, quo_reg, divisor_reg);
    assign doStep = (state_reg == MDU_DIV_RUN) && (iterLeft_reg == {1'b0, cnt_reg}); // RULE_05

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MDU_DIV_IDLE, MDU_DIV_DONE: begin
                state_next = div.start ? MDU_DIV_RUN : MDU_DIV_IDLE;
            end
            MDU_DIV_RUN: begin
                if (cnt_reg == 5'h01) begin
                    state_next = MDU_DIV_DONE;
                end
            end
            default: begin
                state_next = MDU_DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MDU_DIV_IDLE;
            rem_reg <= 33'h0_0000_0000;
            quo_reg <= 32'h0000_0000;
            divisor_reg <= 32'h0000_0000;
            cnt_reg <= 5'h00;
            iterLeft_reg <= 6'h00;
            negQuo_reg <= 1'b0;
            negRem_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (div.start && state_reg != MDU_DIV_RUN) begin
                rem_reg <= startStep ? startStepped[64:32] : 33'h0_0000_0000;
                quo_reg <= startStep ? startStepped[31:0] : dividendMag << skipCount;
                divisor_reg <= divisorMag;
                cnt_reg <= 5'(repeatCount - 6'h01);
                iterLeft_reg <= startStep ? iterCount - 6'h01 : iterCount;
                negQuo_reg <= div.isSigned && (div.dividend[31] ^ div.divisor[31]);
                negRem_reg <= div.isSigned && div.dividend[31];
            end else if (state_reg == MDU_DIV_RUN) begin
                cnt_reg <= cnt_reg - 5'h01;
                if (doStep) begin
                    rem_reg <= runStepped[64:32];
                    quo_reg <= runStepped[31:0];
                    iterLeft_reg <= iterLeft_reg - 6'h01;
                end
            end
        end
    end

    assign div.busy = (state_reg == MDU_DIV_RUN);
    assign div.done = (state_reg == MDU_DIV_DONE);
    assign div.quotient = negQuo_reg ? -quo_reg : quo_reg;
    assign div.remainder = negRem_reg ? -rem_reg[31:0] : rem_reg[31:0];

    // ==========================================================
    // Checks
    // ==========================================================
    wire logic startTaken;
    assign startTaken = div.start && state_reg != MDU_DIV_RUN;

    div_short_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_10
        startTaken && fits8 |=> div.busy [*8] ##0 div.busy ##1 div.busy ##1 div.busy ##1 div.done)
        else $error("Short divide did not finish in its repeat time.");
    div_full_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_10
        startTaken && !fits24 |-> ##31 div.busy ##1 div.done)
        else $error("Full divide did not finish in its repeat time.");
    div_all_steps_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
        div.done |-> iterLeft_reg == 6'h00)
        else $error("Divide ended with quotient bits unresolved.");

endmodule : mdu_divider

`default_nettype wire

//--- rtl/mdu_muldiv_unit.sv
// Multiply/divide unit: booth multiplier, result word pair and divide control.
`timescale 1ns/1ps
`default_nettype none
`include "mdu_defs.svh"

// Functional notes
// RULE_01 - Own pipeline, advances while integer pipeline stalls.
// RULE_02 - Booth array, 32 by 16 per pass.
// RULE_03 - Pass count chosen from second operand only.
// RULE_04 - Narrow multiply each cycle; wide every other.
// RULE_05 - Divider resolves one quotient bit per clock.
// RULE_06 - Dividend width skips 23, 15 or 7 steps.
// RULE_07 - Any issue during active divide stalls.
// RULE_08 - Accumulating multiplies: latency/repeat 1 or 2.
// RULE_09 - Word multiply: latency 2/3, repeat 1/2.
// RULE_10 - Divide latency 12/19/26/33, repeat 11/18/25/32.
// RULE_11 - Signed two's complement; accumulate adds or subtracts.
// RULE_12 - Quotient to low word, remainder to high.
module mdu_muldiv_unit
    import mdu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic issueValid,
    input wire mdu_op_type issueOp,
    input wire logic issueSigned,
    input wire logic [31:0] firstSourceOperand,
    input wire logic [31:0] secondSourceOperand,
    output logic issueStall,
    output logic [31:0] resultHighWord,
    output logic [31:0] resultLowWord,
    output logic hiloValid,
    output logic [31:0] gprResult,
    output logic gprValid
);

    // ==========================================================
    // Issue control
    // ==========================================================
    logic pass2_reg;
    logic [31:0] rsSave_reg;
    logic [15:0] rtHighSave_reg;
    logic signedSave_reg;
    mdu_op_type opSave_reg;
    logic [63:0] lowPartial_reg;

    mdu_div_if divLink ();

    wire logic isMul;
    wire logic narrowOperand;
    wire logic accept;
    wire logic mulAccept;

    assign isMul = (issueOp != MDU_OP_DIV);
    assign narrowOperand = issueSigned ?
        (&secondSourceOperand[31:15] | ~|secondSourceOperand[31:15]) :
        ~|secondSourceOperand[31:16]; // RULE_03
    // The stall depends only on issueValid and the unit's own state, so it advances
    // every clock whatever the integer pipeline is doing.
    assign issueStall = issueValid && (divLink.busy || pass2_reg); // RULE_01 RULE_04 RULE_07
    assign accept = issueValid && !issueStall;
    assign mulAccept = accept && isMul;

    // ==========================================================
    // Booth-recoded 32x16 array
    // ==========================================================
    wire logic [33:0] multiplicand;
    wire logic [16:0] multiplier;
    wire logic [18:0] boothBits;
    wire logic [63:0] partialSum [0:`MDU_BOOTH_DIGITS];

    assign multiplicand = pass2_reg ?
        {{2{signedSave_reg & rsSave_reg[31]}}, rsSave_reg} :
        {{2{issueSigned & firstSourceOperand[31]}}, firstSourceOperand}; // RULE_11
    assign multiplier = pass2_reg ? {signedSave_reg & rtHighSave_reg[15], rtHighSave_reg} :
        {narrowOperand & issueSigned & secondSourceOperand[15],
         secondSourceOperand[15:0]};
    // The sign bit is repeated on top so the last digit selects inside the vector.
    assign boothBits = {multiplier[16], multiplier, 1'b0};
    assign partialSum[0] = 64'h0000_0000_0000_0000;

    genvar digit;
    generate
        for (digit = 0; digit < `MDU_BOOTH_DIGITS; digit++) begin : gBooth
            wire logic [2:0] code;
            wire logic [63:0] aExt;
            wire logic [63:0] term;
            assign code = boothBits[2*digit+2 -: 3];
            assign aExt = {{30{multiplicand[33]}}, multiplicand};
            assign term = (code == 3'h1 || code == 3'h2) ? aExt :
                          (code == 3'h3) ? aExt << 1 :
                          (code == 3'h4) ? -(aExt << 1) :
                          (code == 3'h5 || code == 3'h6) ? -aExt : 64'h0000_0000_0000_0000;
            assign partialSum[digit+1] = partialSum[digit] + (term << (2 * digit)); // RULE_02
        end
    endgenerate

    // ==========================================================
    // Result word pair
    // ==========================================================
    wire logic finalPass;
    wire mdu_op_type finalOp;
    wire logic [63:0] product;
    wire logic [63:0] hiloSource;
    wire logic [63:0] hiloNext;
    wire logic writesHilo;

    assign finalPass = pass2_reg || (mulAccept && narrowOperand);
    assign finalOp = pass2_reg ? opSave_reg : issueOp;
    assign product = pass2_reg ?
        lowPartial_reg + (partialSum[`MDU_BOOTH_DIGITS] << `MDU_HALF) :
        partialSum[`MDU_BOOTH_DIGITS];
    // A multiply finishing as the divide ends sees the divide's result, and
    // being the later instruction its own write wins.
    assign hiloSource = divLink.done ? {divLink.remainder, divLink.quotient} :
                        {resultHighWord, resultLowWord}; // RULE_12
    assign writesHilo = finalPass && finalOp != MDU_OP_MUL;
    assign hiloNext = !writesHilo ? hiloSource :
                      (finalOp == MDU_OP_MADD) ? hiloSource + product :
                      (finalOp == MDU_OP_MSUB) ? hiloSource - product : product; // RULE_11

    assign divLink.start = accept && !isMul;
    assign divLink.isSigned = issueSigned;
    assign divLink.dividend = firstSourceOperand;
    assign divLink.divisor = secondSourceOperand;

    mdu_divider uDivider (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .div(divLink)
    );

    logic [31:0] mulStage_reg;
    logic mulStageValid_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pass2_reg <= 1'b0;
            rsSave_reg <= 32'h0000_0000;
            rtHighSave_reg <= 16'h0000;
            signedSave_reg <= 1'b0;
            opSave_reg <= MDU_OP_MULT;
            lowPartial_reg <= 64'h0000_0000_0000_0000;
        end else begin
            pass2_reg <= mulAccept && !narrowOperand; // RULE_03 RULE_04
            if (mulAccept && !narrowOperand) begin
                rsSave_reg <= firstSourceOperand;
                rtHighSave_reg <= secondSourceOperand[31:16];
                signedSave_reg <= issueSigned;
                opSave_reg <= issueOp;
                lowPartial_reg <= partialSum[`MDU_BOOTH_DIGITS];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resultHighWord <= 32'h0000_0000;
            resultLowWord <= 32'h0000_0000;
            hiloValid <= 1'b0;
            mulStage_reg <= 32'h0000_0000;
            mulStageValid_reg <= 1'b0;
            gprResult <= 32'h0000_0000;
            gprValid <= 1'b0;
        end else begin
            {resultHighWord, resultLowWord} <= hiloNext; // RULE_12
            hiloValid <= writesHilo || divLink.done; // RULE_08 RULE_10
            mulStage_reg <= product[31:0];
            mulStageValid_reg <= finalPass && finalOp == MDU_OP_MUL; // RULE_09
            gprResult <= mulStage_reg;
            gprValid <= mulStageValid_reg;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    wire logic accMul;
    assign accMul = mulAccept && issueOp != MDU_OP_MUL;

    narrow_mult_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
        accMul && narrowOperand |=> hiloValid)
        else $error("Narrow multiply result not ready after one cycle.");
    wide_mult_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
        accMul && !narrowOperand |=> !hiloValid ##1 hiloValid)
        else $error("Wide multiply result not ready after two cycles.");
    wide_back_stall_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        mulAccept && !narrowOperand |=> issueValid |-> issueStall)
        else $error("Back-to-back wide multiply was not stalled.");
    narrow_no_stall_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        issueValid && !divLink.busy && !pass2_reg |-> !issueStall)
        else $error("Issue stalled with the unit free.");
    word_mul_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_09
        mulAccept && issueOp == MDU_OP_MUL |->
        (if (narrowOperand) (##2 gprValid) else (##2 !gprValid ##1 gprValid)))
        else $error("Word multiply latency wrong.");
    div_busy_stall_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
        divLink.start |=> (issueValid |-> issueStall))
        else $error("Issue accepted during an active divide.");
    div_result_place_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
        divLink.done && !writesHilo |=>
        resultLowWord == $past(divLink.quotient) && resultHighWord == $past(divLink.remainder))
        else $error("Divide result placed in wrong words.");
    msub_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_11
        accept && issueOp == MDU_OP_MSUB && narrowOperand && !divLink.done |=>
        {resultHighWord, resultLowWord} ==
        $past({resultHighWord, resultLowWord}) - $past(product))
        else $error("Multiply-subtract result wrong.");

endmodule : mdu_muldiv_unit

`default_nettype wire

//--- rtl/mdu_pkg.sv
// Types of the multiply/divide unit.
package mdu_pkg;

    typedef enum logic [2:0] {
        MDU_OP_MULT = 3'b000,
        MDU_OP_MADD = 3'b001,
        MDU_OP_MSUB = 3'b010,
        MDU_OP_MUL = 3'b011,
        MDU_OP_DIV = 3'b100
    } mdu_op_type;

    typedef enum logic [1:0] {
        MDU_DIV_IDLE = 2'b00,
        MDU_DIV_RUN = 2'b01,
        MDU_DIV_DONE = 2'b10
    } mdu_div_state_type;

endpackage : mdu_pkg

//--- verif/mdu_pipe_model.sv
// Integer pipeline model that offers instructions to the multiply/divide unit.
`timescale 1ns/1ps
`default_nettype none

module mdu_pipe_model
    import mdu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic issueStall,
    output var logic issueValid,
    output var mdu_op_type issueOp,
    output var logic issueSigned,
    output var logic [31:0] firstSourceOperand,
    output var logic [31:0] secondSourceOperand
);
    initial begin
        issueValid = 1'b0;
        issueOp = MDU_OP_MULT;
        issueSigned = 1'b0;
        firstSourceOperand = 32'h0;
        secondSourceOperand = 32'h0;
    end

    // ==========================================================
    // Offer handshake
    // Entered just after a rising edge. The stall is sampled at the falling edge, where it
    // has settled for the coming edge, so the outcome never depends on process order.
    task automatic offer(input mdu_op_type op, input logic sgn, input logic [31:0] a,
                         input logic [31:0] b, output int stalls);
        logic st;
        int n;
        stalls = 0;
        issueValid = 1'b1;
        issueOp = op;
        issueSigned = sgn;
        firstSourceOperand = a;
        secondSourceOperand = b;
        for (n = 0; n < 100; n++) begin
            @(negedge ref_clk);
            st = issueStall;
            @(posedge ref_clk);
            if (st === 1'b0) break;
            stalls++;
        end
        #1;
    endtask : offer

    // Stale operands are inverted so a dropped offer cannot pass for a held one.
    task automatic releaseOffer();
        issueValid = 1'b0;
        firstSourceOperand = ~firstSourceOperand;
        secondSourceOperand = ~secondSourceOperand;
    endtask : releaseOffer
endmodule : mdu_pipe_model

`default_nettype wire

//--- verif/multiply_divide_unit_tb_top.sv
// Self-checking testbench of the multiply/divide unit.
`timescale 1ns/1ps
`default_nettype none

module multiply_divide_unit_tb_top
    import mdu_pkg::*;
;
    typedef struct {
        mdu_op_type op;
        logic sgn;
        logic [31:0] a;
        logic [31:0] b;
        int lat;
    } mdu_row_type;

    logic ref_clk;
    logic rst_n;
    logic issueValid;
    mdu_op_type issueOp;
    logic issueSigned;
    logic [31:0] firstSourceOperand;
    logic [31:0] secondSourceOperand;
    logic issueStall;
    logic [31:0] resultHighWord;
    logic [31:0] resultLowWord;
    logic hiloValid;
    logic [31:0] gprResult;
    logic gprValid;
    int numErrors = 0;
    int checks = 0;
    int midStalls;
    logic [63:0] expHilo;
    mdu_row_type rows [16];

    mdu_muldiv_unit mdu_muldiv_unit_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .issueValid(issueValid),
        .issueOp(issueOp),
        .issueSigned(issueSigned),
        .firstSourceOperand(firstSourceOperand),
        .secondSourceOperand(secondSourceOperand),
        .issueStall(issueStall),
        .resultHighWord(resultHighWord),
        .resultLowWord(resultLowWord),
        .hiloValid(hiloValid),
        .gprResult(gprResult),
        .gprValid(gprValid)
    );

    mdu_pipe_model mdu_pipe_model_inst (
        .ref_clk(ref_clk),
        .issueStall(issueStall),
        .issueValid(issueValid),
        .issueOp(issueOp),
        .issueSigned(issueSigned),
        .firstSourceOperand(firstSourceOperand),
        .secondSourceOperand(secondSourceOperand)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (numErrors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // The whole run needs about 600 cycles; the limit leaves wide margin.
    initial begin
        #(20 * 6000);
        numErrors++;
        test_done();
    end

    // ==========================================================
    // Reference arithmetic, worked out from the operand values, sign flag and expected word pair
    function automatic logic [63:0] calcProduct(input mdu_row_type r);
        logic [63:0] ea;
        logic [63:0] eb;
        ea = r.sgn ? {{32{r.a[31]}}, r.a} : {32'h0, r.a};
        eb = r.sgn ? {{32{r.b[31]}}, r.b} : {32'h0, r.b};
        return ea * eb;
    endfunction : calcProduct

    function automatic logic [63:0] calcResult(input mdu_row_type r, input logic [63:0] hilo);
        logic [63:0] p;
        p = calcProduct(r);
        case (r.op)
            MDU_OP_MADD: return hilo + p;
            MDU_OP_MSUB: return hilo - p;
            MDU_OP_MUL: return hilo;
            MDU_OP_DIV: begin
                if (r.sgn) begin
                    return {32'($signed(r.a) % $signed(r.b)), 32'($signed(r.a) / $signed(r.b))};
                end
                return {r.a % r.b, r.a / r.b};
            end
            default: return p;
        endcase
    endfunction : calcResult

    // ==========================================================
    // Scenario tasks
    task automatic runRow(input mdu_row_type r);
        int stalls;
        int k;
        logic seen;
        logic [63:0] p;
        p = calcProduct(r);
        @(posedge ref_clk);
        #1;
        mdu_pipe_model_inst.offer(r.op, r.sgn, r.a, r.b, stalls);
        mdu_pipe_model_inst.releaseOffer();
        expHilo = calcResult(r, expHilo);
        for (k = 1; k < 40; k++) begin
            @(negedge ref_clk);
            seen = (r.op == MDU_OP_MUL) ? gprValid : hiloValid;
            if (seen === 1'b1) break;
        end
        check(64'(k), 64'(r.lat), "latency");
        check(64'(stalls), 64'h0, "issue stalls");
        check({resultHighWord, resultLowWord}, expHilo, "result pair");
        if (r.op == MDU_OP_MUL) begin
            check(64'(gprResult), {32'h0, p[31:0]}, "word result");
        end
    endtask : runRow

    // A plain narrow multiply follows the first op at once; its stall count is the repeat
    // interval less one. The fixed drain outlasts the longest divide.
    task automatic pairStall(input mdu_row_type r, input int expStalls);
        int stalls;
        @(posedge ref_clk);
        #1;
        mdu_pipe_model_inst.offer(r.op, r.sgn, r.a, r.b, stalls);
        mdu_pipe_model_inst.offer(MDU_OP_MULT, 1'b0, 32'h00000005, 32'h00000003, stalls);
        mdu_pipe_model_inst.releaseOffer();
        check(64'(stalls), 64'(expStalls), "repeat stalls");
        repeat (40) @(posedge ref_clk);
    endtask : pairStall

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        expHilo = 64'h0;
        rows = '{
            '{MDU_OP_MULT, 1'b0, 32'h12345678, 32'h00001234, 1},
            '{MDU_OP_MULT, 1'b1, 32'hFFFFFFF0, 32'hFFFF8000, 1},
            '{MDU_OP_MULT, 1'b0, 32'h0000FFFF, 32'h00008000, 1},
            '{MDU_OP_MULT, 1'b1, 32'h0000FFFF, 32'h00008000, 2},
            '{MDU_OP_MADD, 1'b1, 32'hFFFFFFFD, 32'h00010000, 2},
            '{MDU_OP_MSUB, 1'b0, 32'h00001000, 32'h00000007, 1},
            '{MDU_OP_MADD, 1'b0, 32'hFFFFFFFF, 32'hFFFFFFFF, 2},
            '{MDU_OP_MSUB, 1'b1, 32'h00000011, 32'h80000000, 2},
            '{MDU_OP_MUL, 1'b1, 32'h00000007, 32'hFFFFFFFE, 2},
            '{MDU_OP_MUL, 1'b0, 32'h00000003, 32'h12345678, 3},
            '{MDU_OP_DIV, 1'b0, 32'h000000C8, 32'h00000007, 12},
            '{MDU_OP_DIV, 1'b1, 32'hFFFFFF85, 32'h00000005, 12},
            '{MDU_OP_DIV, 1'b0, 32'h0000ABCD, 32'h00000010, 19},
            '{MDU_OP_DIV, 1'b1, 32'hFF876543, 32'hFFFFFFF7, 26},
            '{MDU_OP_DIV, 1'b0, 32'h80000000, 32'h00000003, 33},
            '{MDU_OP_DIV, 1'b1, 32'h00000080, 32'h00000003, 19}
        };
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check({resultHighWord, resultLowWord}, 64'h0, "reset pair");
        check({29'h0, issueStall, hiloValid, gprValid, gprResult}, 64'h0, "reset flags");
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        foreach (rows[i]) begin
            runRow(rows[i]);
        end
        pairStall('{MDU_OP_MULT, 1'b0, 32'h00000003, 32'h00001234, 1}, 0);
        pairStall('{MDU_OP_MADD, 1'b0, 32'h00000003, 32'h00010000, 2}, 1);
        pairStall('{MDU_OP_MUL, 1'b1, 32'h00000003, 32'hFFFFFFFF, 2}, 0);
        pairStall('{MDU_OP_MUL, 1'b0, 32'h00000003, 32'h00020000, 3}, 1);
        pairStall('{MDU_OP_DIV, 1'b0, 32'h00000020, 32'h00000003, 12}, 10);
        pairStall('{MDU_OP_DIV, 1'b1, 32'hFFFF8000, 32'h00000003, 19}, 17);
        pairStall('{MDU_OP_DIV, 1'b0, 32'h00800000, 32'h00000003, 26}, 24);
        pairStall('{MDU_OP_DIV, 1'b1, 32'h80000000, 32'h00000003, 33}, 31);
        // A reset in mid-divide must abandon it and leave the unit ready at once.
        runRow('{MDU_OP_MULT, 1'b0, 32'h00000002, 32'h00000003, 1});
        @(posedge ref_clk);
        #1;
        mdu_pipe_model_inst.offer(MDU_OP_DIV, 1'b0, 32'h80000000, 32'h00000003, midStalls);
        mdu_pipe_model_inst.releaseOffer();
        check(64'(midStalls), 64'h0, "mid issue stalls");
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        @(negedge ref_clk);
        check({resultHighWord, resultLowWord}, 64'h0, "mid reset pair");
        check({29'h0, issueStall, hiloValid, gprValid, gprResult}, 64'h0, "mid reset flags");
        @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        expHilo = 64'h0;
        runRow('{MDU_OP_MULT, 1'b1, 32'hFFFFFFFF, 32'h00000009, 1});
        test_done();
    end
endmodule : multiply_divide_unit_tb_top

`default_nettype wire
